// >>> inc/cms_pkg.sv
// Shared constants and types for the CAN mode, status and FIFO control block
package cms_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_MASTER_CONTROL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MASTER_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TRANSMIT_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TRANSMIT_PRIORITY = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RECEIVE_FIFO_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_ERROR_IRQ_ENABLE = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_TX_REQUEST = 5'h1C;

  // Reset values and writable masks
  localparam logic [7:0] MCR_RESET = 8'h02;
  localparam logic [7:0] MCR_MASK = 8'h3F;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] IER_MASK = 8'h8F;
  localparam logic [7:0] EIER_RESET = 8'h00;
  localparam logic [7:0] EIER_MASK = 8'h97;

  // master_control_reg fields
  localparam int MCR_AUTO_WAKEUP_ENABLE = 5;
  localparam int MCR_NO_RETRANSMIT = 4;
  localparam int MCR_FIFO_LOCK_ON_OVERRUN = 3;
  localparam int MCR_TX_PRIORITY_SELECT = 2;
  localparam int MCR_SLEEP = 1;
  localparam int MCR_INIT = 0;
  // master_status_reg fields
  localparam int MSR_REC = 5;
  localparam int MSR_TRAN = 4;
  localparam int MSR_WKUP = 3;
  localparam int MSR_ERROR_IRQ_FLAG = 2;
  localparam int MSR_SLEEP_ACKNOWLEDGE = 1;
  localparam int MSR_INIT_ACKNOWLEDGE = 0;
  // transmit status fields (mailbox k at base + k)
  localparam int TSR_TXOK = 4;
  localparam int TSR_RQCP = 0;
  // transmit priority fields
  localparam int TPR_LOW = 5;
  localparam int TPR_TME = 2;
  // receive FIFO status fields
  localparam int RFR_RELEASE = 5;
  localparam int RFR_OVR = 4;
  localparam int RFR_FULL = 3;
  // irq_enable_reg fields
  localparam int IER_WAKEUP_IRQ_ENABLE = 7;
  localparam int IER_FOVIE = 3;
  localparam int IER_FFIE = 2;
  localparam int IER_PENDING_IRQ_ENABLE = 1;
  localparam int IER_TMEIE = 0;
  // error_irq_enable_reg: bit 7 global, low bits match errSet order
  localparam int EIER_ERROR_IRQ_ENABLE = 7;
  // tx request register: request at base + k, abort at base + 4 + k
  localparam int TRQ_REQ = 0;
  localparam int TRQ_ABORT = 4;

  localparam logic [3:0] RECESSIVE_BITS = 4'hB;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  localparam logic [1:0] FIFO_ONE = 2'h1;

  typedef enum logic [1:0] {
    MODE_INIT,
    MODE_SYNC,
    MODE_NORMAL,
    MODE_SLEEP
  } cms_mode_e;

  // Status and strobes from the CAN protocol engine
  typedef struct packed {
    logic rxActive;
    logic txActive;
    logic bitTick;
    logic txDone;
    logic txSuccess;
    logic rxStore;
    logic [3:0] errSet;
  } cms_core_in_s;

  // Commands to the CAN protocol engine
  typedef struct packed {
    logic txStart;
    logic txMailbox;
    logic rxAccept;
    logic rxOverwrite;
    logic busOn;
  } cms_core_out_s;

endpackage : cms_pkg

// >>> logic/cms_ctrl.sv
// CAN controller mode, transmit status and receive FIFO control logic
// Behaviour
// RULE1 - Auto wake-up on bus activity clears sleep
// RULE2 - Retransmit until success unless no-retransmit set
// RULE3 - Full FIFO: overwrite, or discard when locked
// RULE4 - Tx order by identifier or request order
// RULE5 - Sleep only after current frame; acknowledge
// RULE6 - Leave init after 11 recessive bits
// RULE7 - Init entered after current frame; acknowledge
// RULE8 - Status flags cleared by writing one
// RULE9 - Read-only receiver and transmitter status bits
// RULE10 - Wake-up flag on start-of-frame in sleep
// RULE11 - Error flag from enabled error-status bits
// RULE12 - Tx success flag set, cleared on rerequest
// RULE13 - Request-completed flag after transmit or abort
// RULE14 - Lowest-priority flag only with two pending
// RULE15 - Mailbox empty flag when nothing pending
// RULE16 - Code gives next free or lowest mailbox
// RULE17 - FIFO release ignored when empty, self-clears
// RULE18 - Overrun flag when storing into full FIFO
// RULE19 - Full flag at three messages, cleared
// RULE20 - Pending count up on store, down release
// RULE21 - Pending interrupt on count leaving zero
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module cms_ctrl
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CAN receive pin
  input wire logic canRx,
  // Protocol engine
  input wire cms_core_in_s coreIn,
  input wire logic [28:0] txId0,
  input wire logic [28:0] txId1,
  output cms_core_out_s coreOut,
  // Interrupt lines
  output logic statusIrq,
  output logic fifoIrq,
  output logic txIrq
);

  logic [7:0] ctrlReg;
  logic [7:0] irqEnReg;
  logic [7:0] errEnReg;
  cms_mode_e mode;
  cms_mode_e next_mode;
  logic init_acknowledge;
  logic sleep_acknowledge;
  logic wakeupFlag;
  logic errorFlag;
  logic isReceiver;
  logic isTransmitter;
  logic rxS1;
  logic rxS2;
  logic rxS3;
  logic rxLevel;
  logic rxLevelPrev;
  logic [3:0] recCount;
  logic [1:0] pending;
  logic [1:0] txOk;
  logic [1:0] reqDone;
  logic txBusy;
  logic txSel;
  logic older;
  logic [1:0] fifoCount;
  logic fifoFull;
  logic fifoOvr;
  logic releaseBit;

  // Bus access decode
  logic busReq;
  logic wrEn;
  logic [7:0] wrData;
  logic [7:0] readMux;
  assign busReq = avs_read | avs_write;
  assign wrEn = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wrData = avs_writedata[7:0];

  logic wrMcr;
  logic wrMsr;
  logic wrTsr;
  logic wrRfr;
  logic wrTrq;
  assign wrMcr = wrEn && avs_address == OFS_MASTER_CONTROL;
  assign wrMsr = wrEn && avs_address == OFS_MASTER_STATUS;
  assign wrTsr = wrEn && avs_address == OFS_TRANSMIT_STATUS;
  assign wrRfr = wrEn && avs_address == OFS_RECEIVE_FIFO_STATUS;
  assign wrTrq = wrEn && avs_address == OFS_TX_REQUEST;

  logic busy;
  logic autoWake;
  logic sofSeen;
  assign busy = coreIn.rxActive | coreIn.txActive | txBusy;
  assign sofSeen = rxLevelPrev & ~rxLevel;
  assign autoWake = mode == MODE_SLEEP && ctrlReg[MCR_AUTO_WAKEUP_ENABLE] && !rxLevel;

  // Transmit arbitration
  logic lowMb;
  logic bothPending;
  logic winner;
  logic [1:0] reqSet;
  logic [1:0] abortNow;
  logic [1:0] doneNow;
  logic [1:0] okNow;
  logic [1:0] rqcpClr;
  logic startTx;
  assign bothPending = &pending;
  // Lowest priority mailbox; identifier tie makes mailbox 1 the lowest
  assign lowMb = ctrlReg[MCR_TX_PRIORITY_SELECT] ? ~older : ~(txId1 < txId0); // RULE4
  assign winner = bothPending ? ~lowMb : pending[1]; // RULE4
  assign reqSet = {2{wrTrq}} & wrData[TRQ_REQ +: 2] & ~pending;
  assign startTx = next_mode == MODE_NORMAL && mode == MODE_NORMAL
    && !txBusy && !coreIn.txActive && |pending; // RULE7
  assign rqcpClr = {2{wrTsr}} & wrData[TSR_RQCP +: 2]; // RULE8

  always_comb begin
    abortNow = {2{wrTrq}} & wrData[TRQ_ABORT +: 2] & pending;
    if (txBusy) begin
      abortNow[txSel] = 1'b0;
    end
    doneNow = 2'b00;
    okNow = 2'b00;
    if (txBusy && coreIn.txDone) begin
      okNow[txSel] = coreIn.txSuccess;
      doneNow[txSel] = coreIn.txSuccess | ctrlReg[MCR_NO_RETRANSMIT]; // RULE2
    end
  end

  // FIFO release and store
  logic doRelease;
  logic storeOk;
  logic [1:0] next_fifoCount;
  assign doRelease = releaseBit && fifoCount != FIFO_EMPTY; // RULE17
  assign storeOk = coreIn.rxStore && (fifoCount != FIFO_DEPTH || doRelease);

  always_comb begin
    next_fifoCount = fifoCount;
    if (storeOk && !doRelease) begin
      next_fifoCount = fifoCount + FIFO_ONE; // RULE20
    end else if (doRelease && !storeOk) begin
      next_fifoCount = fifoCount - FIFO_ONE; // RULE20
    end
  end

  // Bus handshake: one wait cycle, data registered with the answer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, readMux};
      end
    end
  end

  always_comb begin
    readMux = 8'h00;
    unique case (avs_address)
      OFS_MASTER_CONTROL: readMux = ctrlReg;
      OFS_MASTER_STATUS: begin
        readMux[MSR_REC] = isReceiver; // RULE9
        readMux[MSR_TRAN] = isTransmitter; // RULE9
        readMux[MSR_WKUP] = wakeupFlag;
        readMux[MSR_ERROR_IRQ_FLAG] = errorFlag;
        readMux[MSR_SLEEP_ACKNOWLEDGE] = sleep_acknowledge;
        readMux[MSR_INIT_ACKNOWLEDGE] = init_acknowledge;
      end
      OFS_TRANSMIT_STATUS: begin
        readMux[TSR_TXOK +: 2] = txOk;
        readMux[TSR_RQCP +: 2] = reqDone;
      end
      OFS_TRANSMIT_PRIORITY: begin
        readMux[TPR_LOW +: 2] = bothPending ? {lowMb, ~lowMb} : 2'b00; // RULE14
        readMux[TPR_TME +: 2] = ~pending; // RULE15
        readMux[0] = !pending[0] ? 1'b0 : (!pending[1] ? 1'b1 : lowMb); // RULE16
      end
      OFS_RECEIVE_FIFO_STATUS: begin
        readMux[RFR_RELEASE] = releaseBit;
        readMux[RFR_OVR] = fifoOvr;
        readMux[RFR_FULL] = fifoFull;
        readMux[1:0] = fifoCount;
      end
      OFS_IRQ_ENABLE: readMux = irqEnReg;
      OFS_ERROR_IRQ_ENABLE: readMux = errEnReg;
      OFS_TX_REQUEST: readMux[TRQ_REQ +: 2] = pending;
      default: readMux = 8'h00;
    endcase
  end

  // Software control; sleep request also dropped by auto wake-up
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrlReg <= MCR_RESET;
      irqEnReg <= IER_RESET;
      errEnReg <= EIER_RESET;
    end else begin
      if (wrMcr) begin
        ctrlReg <= wrData & MCR_MASK;
      end else if (autoWake) begin
        ctrlReg[MCR_SLEEP] <= 1'b0; // RULE1
      end
      if (wrEn && avs_address == OFS_IRQ_ENABLE) begin
        irqEnReg <= wrData & IER_MASK;
      end
      if (wrEn && avs_address == OFS_ERROR_IRQ_ENABLE) begin
        errEnReg <= wrData & EIER_MASK;
      end
    end
  end

  // Rx pin filter: change taken once second and third stage agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxS3 <= 1'b1;
      rxLevel <= 1'b1;
      rxLevelPrev <= 1'b1;
    end else begin
      rxS1 <= canRx;
      rxS2 <= rxS1;
      rxS3 <= rxS2;
      if (rxS2 == rxS3) begin
        rxLevel <= rxS3;
      end
      rxLevelPrev <= rxLevel;
    end
  end

  // Operating mode
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_NORMAL: begin
        if (ctrlReg[MCR_INIT] && !busy) begin
          next_mode = MODE_INIT; // RULE7
        end else if (ctrlReg[MCR_SLEEP] && !busy) begin
          next_mode = MODE_SLEEP; // RULE5
        end
      end
      MODE_INIT: begin
        if (!ctrlReg[MCR_INIT]) begin
          next_mode = MODE_SYNC;
        end
      end
      MODE_SYNC: begin
        if (ctrlReg[MCR_INIT]) begin
          next_mode = MODE_INIT;
        end else if (recCount == RECESSIVE_BITS) begin
          next_mode = MODE_NORMAL; // RULE6
        end
      end
      MODE_SLEEP: begin
        if (ctrlReg[MCR_INIT]) begin
          next_mode = MODE_INIT;
        end else if (!ctrlReg[MCR_SLEEP] || autoWake) begin
          next_mode = MODE_SYNC; // RULE1
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode <= MODE_SLEEP;
      sleep_acknowledge <= 1'b1;
      init_acknowledge <= 1'b0;
      recCount <= 4'h0;
    end else begin
      mode <= next_mode;
      sleep_acknowledge <= next_mode == MODE_SLEEP; // RULE5
      if (next_mode == MODE_INIT) begin
        init_acknowledge <= 1'b1; // RULE7
      end else if (next_mode == MODE_NORMAL) begin
        init_acknowledge <= 1'b0; // RULE6
      end
      // Consecutive recessive samples at bit ticks
      if (mode != MODE_SYNC || !rxLevel) begin
        recCount <= 4'h0;
      end else if (coreIn.bitTick && recCount != RECESSIVE_BITS) begin
        recCount <= recCount + 4'h1; // RULE6
      end
    end
  end

  // Master status flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wakeupFlag <= 1'b0;
      errorFlag <= 1'b0;
      isReceiver <= 1'b0;
      isTransmitter <= 1'b0;
    end else begin
      isReceiver <= coreIn.rxActive; // RULE9
      isTransmitter <= coreIn.txActive; // RULE9
      if (mode == MODE_SLEEP && sofSeen) begin
        wakeupFlag <= 1'b1; // RULE10
      end else if (wrMsr && wrData[MSR_WKUP]) begin
        wakeupFlag <= 1'b0; // RULE8
      end
      if (|(coreIn.errSet & errEnReg[3:0])) begin
        errorFlag <= 1'b1; // RULE11
      end else if (wrMsr && wrData[MSR_ERROR_IRQ_FLAG]) begin
        errorFlag <= 1'b0; // RULE8
      end
    end
  end

  // Transmit mailboxes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pending <= 2'b00;
      txOk <= 2'b00;
      reqDone <= 2'b00;
      txBusy <= 1'b0;
      txSel <= 1'b0;
      older <= 1'b0;
    end else begin
      pending <= (pending | reqSet) & ~doneNow & ~abortNow; // RULE2
      reqDone <= (reqDone & ~rqcpClr) | doneNow | abortNow; // RULE13
      txOk <= (txOk & ~(reqSet | rqcpClr)) | okNow; // RULE12
      if (reqSet == 2'b11 || (reqSet[0] && !pending[1])) begin
        older <= 1'b0; // RULE4
      end else if (reqSet[1] && !pending[0]) begin
        older <= 1'b1; // RULE4
      end else if (reqSet != 2'b00) begin
        older <= reqSet[0]; // RULE4
      end
      if (startTx) begin
        txBusy <= 1'b1;
        txSel <= winner;
      end else if (coreIn.txDone) begin
        txBusy <= 1'b0;
      end
    end
  end

  // Receive FIFO bookkeeping
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fifoCount <= FIFO_EMPTY;
      fifoFull <= 1'b0;
      fifoOvr <= 1'b0;
      releaseBit <= 1'b0;
    end else begin
      fifoCount <= next_fifoCount;
      if (wrRfr && wrData[RFR_RELEASE]) begin
        releaseBit <= 1'b1;
      end else begin
        releaseBit <= 1'b0; // RULE17
      end
      if (storeOk && next_fifoCount == FIFO_DEPTH) begin
        fifoFull <= 1'b1; // RULE19
      end else if (doRelease || (wrRfr && wrData[RFR_FULL])) begin
        fifoFull <= 1'b0; // RULE19
      end
      if (coreIn.rxStore && !storeOk) begin
        fifoOvr <= 1'b1; // RULE18
      end else if (wrRfr && wrData[RFR_OVR]) begin
        fifoOvr <= 1'b0; // RULE8
      end
    end
  end

  // Engine commands and interrupt lines, all registered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      coreOut <= '0;
      statusIrq <= 1'b0;
      fifoIrq <= 1'b0;
      txIrq <= 1'b0;
    end else begin
      coreOut.txStart <= startTx;
      if (startTx) begin
        coreOut.txMailbox <= winner;
      end
      coreOut.rxAccept <= storeOk;
      // Locked FIFO drops the frame, unlocked replaces the newest
      coreOut.rxOverwrite <= coreIn.rxStore && !storeOk
        && !ctrlReg[MCR_FIFO_LOCK_ON_OVERRUN]; // RULE3
      coreOut.busOn <= next_mode == MODE_NORMAL;
      statusIrq <= (wakeupFlag & irqEnReg[IER_WAKEUP_IRQ_ENABLE]) // RULE10
        | (errorFlag & errEnReg[EIER_ERROR_IRQ_ENABLE]); // RULE11
      fifoIrq <= (irqEnReg[IER_PENDING_IRQ_ENABLE] && fifoCount != FIFO_EMPTY) // RULE21
        | (irqEnReg[IER_FFIE] & fifoFull)
        | (irqEnReg[IER_FOVIE] & fifoOvr);
      txIrq <= irqEnReg[IER_TMEIE] & |reqDone;
    end
  end

endmodule : cms_ctrl

// >>> tb/cms_engine_model.sv
// Protocol engine and CAN bus stand-in facing the control block
`timescale 1ns/1ps
module cms_engine_model
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Block side
  input wire cms_core_out_s coreOut,
  output cms_core_in_s coreIn,
  output logic canRx,
  // Bench commands
  input wire logic failTx,
  input wire logic rxGo,
  input wire logic rxLow,
  input wire logic [3:0] errGo
);
  logic [3:0] txCnt;
  logic [1:0] tick;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick <= 2'h0;
      txCnt <= 4'h0;
    end else begin
      tick <= tick + 2'h1;
      if (coreOut.txStart)
        txCnt <= 4'hF;
      else if (txCnt != 4'h0)
        txCnt <= txCnt - 4'h1;
    end
  end
  // Long frames so mode requests land mid-frame
  always_comb begin
    coreIn = '0;
    coreIn.bitTick = (tick == 2'h3);
    coreIn.rxActive = rxLow;
    coreIn.txActive = (txCnt > 4'h1);
    coreIn.txDone = (txCnt == 4'h1);
    coreIn.txSuccess = coreIn.txDone && !failTx;
    coreIn.rxStore = rxGo;
    coreIn.errSet = errGo;
  end
  // Bus idles recessive; dominant only on command
  assign canRx = !rxLow;
endmodule : cms_engine_model

// >>> tb/cms_ctrl_assertions.sv
// Port-level checks for the control block
`timescale 1ns/1ps
module cms_ctrl_assertions
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Engine and pin
  input wire logic canRx,
  input wire cms_core_in_s coreIn,
  input wire logic [28:0] txId0,
  input wire logic [28:0] txId1,
  input wire cms_core_out_s coreOut,
  // Interrupt lines
  input wire logic statusIrq,
  input wire logic fifoIrq,
  input wire logic txIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus_ack;
    s_req |=> s_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("access not answered in one wait cycle");
  property p_bus_idle;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_bus_idle: assert property (p_bus_idle)
    else $error("waitrequest low without request");
  property p_tx_once;
    coreOut.txStart |=> !coreOut.txStart;
  endproperty
  a_tx_once: assert property (p_tx_once)
    else $error("start pulse too long");
  property p_no_start_busy;
    coreIn.txActive |=> !coreOut.txStart;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy)
    else $error("start while frame on bus");
  property p_done_gap;
    coreIn.txDone |=> !coreOut.txStart;
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("start right after frame end");
  property p_start_on;
    coreOut.txStart |-> $past(coreOut.busOn);
  endproperty
  a_start_on: assert property (p_start_on)
    else $error("start outside normal mode");
  property p_rx_answer;
    coreIn.rxStore |=> !(coreOut.rxAccept && coreOut.rxOverwrite);
  endproperty
  a_rx_answer: assert property (p_rx_answer)
    else $error("store and overwrite together");
  property p_rx_cause;
    (coreOut.rxAccept || coreOut.rxOverwrite) |-> $past(coreIn.rxStore);
  endproperty
  a_rx_cause: assert property (p_rx_cause)
    else $error("store without received frame");
endmodule : cms_ctrl_assertions

// >>> tb/cms_ctrl_tb.sv
// Self-checking bench for the CAN mode, status and FIFO control block
`timescale 1ns/1ps
module cms_ctrl_tb;
  import cms_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic canRx;
  cms_core_in_s coreIn;
  cms_core_out_s coreOut;
  logic [28:0] txId0 = 29'h100;
  logic [28:0] txId1 = 29'h050;
  logic statusIrq;
  logic fifoIrq;
  logic txIrq;
  logic failTx = 1'b0;
  logic rxGo = 1'b0;
  logic rxLow = 1'b0;
  logic [3:0] errGo = 4'h0;
  logic [7:0] rdv;
  logic ow;
  int fails = 0;
  int cmp_count = 0;
  cms_ctrl cms_ctrl_inst (.*);
  cms_engine_model cms_engine_model_inst (.*);
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic w, logic [ADDR_W-1:0] a, logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : acc
  task automatic rchk(input logic [ADDR_W-1:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg%h", a), rdv, e);
  endtask : rchk
  task automatic wstart(input logic e);
    int n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (coreOut.txStart !== 1'b1 && n < 300);
    chk("started", {7'h0, coreOut.txStart}, 8'h01);
    chk("mailbox", {7'h0, coreOut.txMailbox}, {7'h0, e});
  endtask : wstart
  task automatic rxp();
    rxGo <= 1'b1;
    @(posedge sys_clk);
    rxGo <= 1'b0;
    @(posedge sys_clk);
    ow = coreOut.rxOverwrite;
  endtask : rxp
  task automatic starts(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge sys_clk);
      if (coreOut.txStart === 1'b1)
        n++;
    end
  endtask : starts
  task automatic pulse_in(input logic [3:0] v, logic dom);
    errGo <= v;
    rxLow <= dom;
    cyc(8);
    errGo <= 4'h0;
    rxLow <= 1'b0;
    cyc(4);
  endtask : pulse_in
  task automatic t_reset();
    rchk(OFS_MASTER_CONTROL, 8'h02);
    rchk(OFS_MASTER_STATUS, 8'h02);
    rchk(OFS_TRANSMIT_PRIORITY, 8'h0C);
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h00);
  endtask : t_reset
  task automatic t_init();
    acc(1'b1, OFS_MASTER_CONTROL, 8'h01);
    cyc(20);
    rchk(OFS_MASTER_STATUS, 8'h01);
    acc(1'b1, OFS_MASTER_CONTROL, 8'h00);
    cyc(12);
    rchk(OFS_MASTER_STATUS, 8'h01);
    cyc(48);
    rchk(OFS_MASTER_STATUS, 8'h00);
  endtask : t_init
  task automatic t_tx();
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    wstart(1'b0);
    cyc(20);
    rchk(OFS_TRANSMIT_STATUS, 8'h11);
    rchk(OFS_TRANSMIT_PRIORITY, 8'h0C);
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    rchk(OFS_TRANSMIT_STATUS, 8'h01);
    cyc(24);
    acc(1'b1, OFS_TRANSMIT_STATUS, 8'h00);
    acc(1'b1, OFS_IRQ_ENABLE, 8'h01);
    rchk(OFS_TRANSMIT_STATUS, 8'h11);
    chk("txIrq", {7'h0, txIrq}, 8'h01);
    acc(1'b1, OFS_TRANSMIT_STATUS, 8'h01);
    rchk(OFS_TRANSMIT_STATUS, 8'h00);
    chk("txIrq", {7'h0, txIrq}, 8'h00);
  endtask : t_tx
  task automatic t_prio(input logic [7:0] mode, logic [7:0] tp, logic f);
    acc(1'b1, OFS_MASTER_CONTROL, mode | 8'h01);
    cyc(20);
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    acc(1'b1, OFS_TX_REQUEST, 8'h02);
    rchk(OFS_TRANSMIT_PRIORITY, tp);
    acc(1'b1, OFS_MASTER_CONTROL, mode);
    wstart(f);
    wstart(!f);
    cyc(20);
    acc(1'b1, OFS_TRANSMIT_STATUS, 8'h03);
  endtask : t_prio
  task automatic t_no_retransmit();
    int n;
    acc(1'b1, OFS_MASTER_CONTROL, 8'h10);
    failTx <= 1'b1;
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    starts(80, n);
    chk("once", n[7:0], 8'h01);
    rchk(OFS_TRANSMIT_STATUS, 8'h01);
    acc(1'b1, OFS_TRANSMIT_STATUS, 8'h01);
    acc(1'b1, OFS_MASTER_CONTROL, 8'h00);
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    starts(50, n);
    chk("retry", {7'h0, n >= 2}, 8'h01);
    failTx <= 1'b0;
    cyc(40);
    rchk(OFS_TRANSMIT_STATUS, 8'h11);
    acc(1'b1, OFS_TRANSMIT_STATUS, 8'h01);
  endtask : t_no_retransmit
  task automatic t_fifo(input logic lock);
    acc(1'b1, OFS_MASTER_CONTROL, {4'h0, lock, 3'h0});
    rxp();
    cyc(2);
    chk("fifoIrq", {7'h0, fifoIrq}, 8'h01);
    rxp();
    rxp();
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h0B);
    rxp();
    chk("overwrite", {7'h0, ow}, {7'h0, !lock});
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h1B);
    acc(1'b1, OFS_RECEIVE_FIFO_STATUS, 8'h20);
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h12);
    repeat (3) acc(1'b1, OFS_RECEIVE_FIFO_STATUS, 8'h20);
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h10);
    acc(1'b1, OFS_RECEIVE_FIFO_STATUS, 8'h10);
    rchk(OFS_RECEIVE_FIFO_STATUS, 8'h00);
    chk("fifoIrq", {7'h0, fifoIrq}, 8'h00);
  endtask : t_fifo
  task automatic t_err();
    acc(1'b1, OFS_ERROR_IRQ_ENABLE, 8'h81);
    rxLow <= 1'b1;
    cyc(2);
    rchk(OFS_MASTER_STATUS, 8'h20);
    rxLow <= 1'b0;
    cyc(4);
    pulse_in(4'h2, 1'b0);
    rchk(OFS_MASTER_STATUS, 8'h00);
    pulse_in(4'h1, 1'b0);
    chk("statusIrq", {7'h0, statusIrq}, 8'h01);
    rchk(OFS_MASTER_STATUS, 8'h04);
    acc(1'b1, OFS_MASTER_STATUS, 8'h04);
    rchk(OFS_MASTER_STATUS, 8'h00);
  endtask : t_err
  task automatic t_sleep();
    acc(1'b1, OFS_TX_REQUEST, 8'h01);
    cyc(4);
    acc(1'b1, OFS_MASTER_CONTROL, 8'h02);
    rchk(OFS_MASTER_STATUS, 8'h10);
    cyc(24);
    rchk(OFS_MASTER_STATUS, 8'h02);
    pulse_in(4'h0, 1'b1);
    rchk(OFS_MASTER_STATUS, 8'h0A);
    acc(1'b1, OFS_MASTER_STATUS, 8'h08);
    acc(1'b1, OFS_MASTER_CONTROL, 8'h22);
    pulse_in(4'h0, 1'b1);
    rchk(OFS_MASTER_CONTROL, 8'h20);
    rchk(OFS_MASTER_STATUS, 8'h08);
  endtask : t_sleep
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_init();
    t_tx();
    t_prio(8'h00, 8'h20, 1'b1);
    t_prio(8'h04, 8'h41, 1'b0);
    t_no_retransmit();
    acc(1'b1, OFS_IRQ_ENABLE, 8'h02);
    t_fifo(1'b0);
    t_fifo(1'b1);
    t_err();
    t_sleep();
    stop_test();
  end
  // Whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
endmodule : cms_ctrl_tb
bind cms_ctrl cms_ctrl_assertions cms_ctrl_assertions_inst (.*);
